// file: src/option_cfg_pkg.sv
// package for the option byte configuration decoder
// assumes one clock domain; shared by the decoder and its interrupt router
package option_cfg_pkg;
  // option byte 0 field positions
  localparam int WRITE_LOCK_BIT = 0;
  // option byte 1 field positions
  localparam int IRQ_MAP_BIT = 7;
  localparam int RESERVED_BIT = 6;
  localparam int OSC_SRC_HI = 5;
  localparam int OSC_SRC_LO = 4;
  localparam int OSC_RANGE_HI = 3;
  localparam int OSC_RANGE_LO = 1;
  localparam int DOUBLER_OFF_BIT = 0;
  // erased defaults of the two option bytes
  localparam logic [7:0] OPT0_RESET = 8'hfc;
  localparam logic [7:0] OPT1_RESET = 8'hef;
  // port widths
  localparam int PORTA_WIDTH = 8;
  localparam int PORTB_WIDTH = 8;
  localparam int PORTC_WIDTH = 6;
  // cycles of reset-release settling before the snapshot is taken
  localparam logic [1:0] SAMPLE_DELAY = 2'h2;

  typedef enum logic [1:0] {
    SRC_RESONATOR,
    SRC_RESERVED,
    SRC_INTERNAL_RC,
    SRC_EXTERNAL
  } osc_source_type;

  typedef enum logic [2:0] {
    RANGE_VERY_LOW_POWER,
    RANGE_ONE_TO_TWO_MHZ,
    RANGE_TWO_TO_FOUR_MHZ,
    RANGE_FOUR_TO_EIGHT_MHZ,
    RANGE_EIGHT_TO_SIXTEEN_MHZ
  } osc_range_type;

  localparam logic [1:0] OSC_SRC_RESONATOR = 2'h0;
  localparam logic [1:0] OSC_SRC_INTERNAL_RC = 2'h2;
  localparam logic [1:0] OSC_SRC_EXTERNAL = 2'h3;
  localparam logic [2:0] RANGE_CODE_1_2 = 3'h0;
  localparam logic [2:0] RANGE_CODE_2_4 = 3'h1;
  localparam logic [2:0] RANGE_CODE_4_8 = 3'h2;
  localparam logic [2:0] RANGE_CODE_8_16 = 3'h3;
endpackage

// file: src/irq_route_if.sv
// interface carrying map select and port lines between decoder and router
// assumes both ends on i_clock
interface irq_route_if;
  logic map_select;
  logic [7:0] porta;
  logic [7:0] portb;
  logic [5:0] portc;
  logic first;
  logic second;
  modport decoder (output map_select, output porta, output portb, output portc,
    input first, input second);
  modport router (input map_select, input porta, input portb, input portc,
    output first, output second);
endinterface

// file: src/ext_irq_router.sv
// routes port interrupt lines onto the two external vectors
// assumes registered map select from the decoder, same clock
module ext_irq_router (
  input wire logic i_clock,
  input wire logic i_arst_n,
  irq_route_if.router bus
);
  import option_cfg_pkg::*;

  logic c_on_second;
  logic next_first;
  logic next_second;

  // port c follows the map bit; a and b are fixed
  assign c_on_second = bus.map_select;
  assign next_first = (|bus.porta) | (~c_on_second & (|bus.portc));
  assign next_second = (|bus.portb) | (c_on_second & (|bus.portc));

  // registered so the top outputs come from flops
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bus.first <= 1'b0;
      bus.second <= 1'b0;
    end else begin
      bus.first <= next_first;
      bus.second <= next_second;
    end
  end
endmodule // ext_irq_router

// file: src/option_byte_config_decode.sv
// option byte decoder: snapshots both option bytes after reset, decodes them
// assumes option bytes are static nonvolatile levels from outside the clock domain
// assumes port interrupt lines and the write request are driven on i_clock
module option_byte_config_decode (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic [7:0] i_option_byte0,
  input wire logic [7:0] i_option_byte1,
  input wire logic [option_cfg_pkg::PORTA_WIDTH-1:0] i_porta_irq,
  input wire logic [option_cfg_pkg::PORTB_WIDTH-1:0] i_portb_irq,
  input wire logic [option_cfg_pkg::PORTC_WIDTH-1:0] i_portc_irq,
  input wire logic i_flash_write_req,
  output logic o_flash_write_lock,
  output logic o_flash_write_grant,
  output logic o_portc_irq_map_select,
  output logic o_ext_irq_vector_first,
  output logic o_ext_irq_vector_second,
  output option_cfg_pkg::osc_source_type o_osc_source_select,
  output option_cfg_pkg::osc_range_type o_osc_range_select,
  output logic o_doubler_enable,
  output logic o_config_valid,
  output logic o_config_illegal
);
  import option_cfg_pkg::*;

  // three-stage synchronisers for the option byte levels
  logic [7:0] opt0_meta;
  logic [7:0] opt0_sync;
  logic [7:0] opt0_sync2;
  logic [7:0] opt1_meta;
  logic [7:0] opt1_sync;
  logic [7:0] opt1_sync2;
  logic [1:0] delay_count;
  logic sampled;
  // held copies, taken once per reset
  logic [7:0] opt0_held;
  logic [7:0] opt1_held;

  // bits agree between stages two and three before snapshot
  logic stable;
  logic take_snapshot;
  logic [1:0] src_field;
  logic [2:0] range_field;
  logic next_lock;
  logic next_doubler;
  logic next_illegal;
  osc_source_type next_source;
  osc_range_type next_range;
  logic next_grant;
  logic count_done;
  logic src_reserved;
  logic doubler_with_rc;
  logic doubler_bad_range;
  logic map_bit;

  // carrier between the decoder and the interrupt router
  irq_route_if route ();

  // snapshot waits for a full chain and matching last two stages
  assign count_done = (delay_count == SAMPLE_DELAY);
  assign stable = (opt0_sync == opt0_sync2) && (opt1_sync == opt1_sync2);
  assign take_snapshot = !sampled && count_done && stable;

  // synchroniser chain for the first byte; stage one feeds only stage two
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      opt0_meta <= OPT0_RESET;
      opt0_sync <= OPT0_RESET;
      opt0_sync2 <= OPT0_RESET;
    end else begin
      opt0_meta <= i_option_byte0;
      opt0_sync <= opt0_meta;
      opt0_sync2 <= opt0_sync;
    end
  end

  // same chain for the second byte; erased reset values read as the default setting
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      opt1_meta <= OPT1_RESET;
      opt1_sync <= OPT1_RESET;
      opt1_sync2 <= OPT1_RESET;
    end else begin
      opt1_meta <= i_option_byte1;
      opt1_sync <= opt1_meta;
      opt1_sync2 <= opt1_sync;
    end
  end

  // settle counter; stops at the limit so it never wraps back to zero
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      delay_count <= 2'h0;
    end else if (!count_done) begin
      delay_count <= delay_count + 2'h1;
    end
  end

  // one snapshot per reset; later changes on the pins are ignored
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sampled <= 1'b0;
      opt0_held <= OPT0_RESET;
      opt1_held <= OPT1_RESET;
    end else if (take_snapshot) begin
      sampled <= 1'b1;
      opt0_held <= opt0_sync2;
      opt1_held <= opt1_sync2;
    end
  end

  // field extraction from the held copy; bit 6 of byte 1 is ignored
  assign src_field = opt1_held[OSC_SRC_HI:OSC_SRC_LO];
  assign range_field = opt1_held[OSC_RANGE_HI:OSC_RANGE_LO];
  assign next_lock = opt0_held[WRITE_LOCK_BIT];
  assign next_doubler = ~opt1_held[DOUBLER_OFF_BIT];

  // source decode; 01 is flagged rather than guessed
  always_comb begin
    unique case (src_field)
      OSC_SRC_RESONATOR: next_source = SRC_RESONATOR;
      OSC_SRC_INTERNAL_RC: next_source = SRC_INTERNAL_RC;
      OSC_SRC_EXTERNAL: next_source = SRC_EXTERNAL;
      default: next_source = SRC_RESERVED;
    endcase
  end

  // range decode; top bit wins regardless of the low bits
  always_comb begin
    if (range_field[2]) begin
      next_range = RANGE_VERY_LOW_POWER;
    end else begin
      unique case (range_field)
        RANGE_CODE_1_2: next_range = RANGE_ONE_TO_TWO_MHZ;
        RANGE_CODE_2_4: next_range = RANGE_TWO_TO_FOUR_MHZ;
        RANGE_CODE_4_8: next_range = RANGE_FOUR_TO_EIGHT_MHZ;
        default: next_range = RANGE_EIGHT_TO_SIXTEEN_MHZ;
      endcase
    end
  end

  // illegal combinations the programmer must avoid; reported, not corrected
  assign src_reserved = (next_source == SRC_RESERVED);
  assign doubler_with_rc = next_doubler && (next_source == SRC_INTERNAL_RC);
  assign doubler_bad_range = next_doubler && (next_range != RANGE_TWO_TO_FOUR_MHZ);
  assign next_illegal = src_reserved || doubler_with_rc || doubler_bad_range;

  // writes are refused while the lock is set or before the snapshot
  assign next_grant = i_flash_write_req && sampled && !next_lock;

  // port lines into the router; the map bit comes from the held copy, never the pins
  assign map_bit = opt1_held[IRQ_MAP_BIT];
  assign route.map_select = map_bit;
  assign route.porta = i_porta_irq;
  assign route.portb = i_portb_irq;
  assign route.portc = i_portc_irq;

  // the router registers its vectors, so a line meets two flops in all
  ext_irq_router router (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .bus(route.router)
  );

  // write lock and grant; lock reads as set until the snapshot is in
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_flash_write_lock <= 1'b1;
      o_flash_write_grant <= 1'b0;
    end else begin
      o_flash_write_lock <= !sampled || next_lock;
      o_flash_write_grant <= next_grant;
    end
  end

  // interrupt routing outputs; two cycles from a port line to its vector
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_portc_irq_map_select <= 1'b1;
      o_ext_irq_vector_first <= 1'b0;
      o_ext_irq_vector_second <= 1'b0;
    end else begin
      o_portc_irq_map_select <= route.map_select;
      o_ext_irq_vector_first <= route.first;
      o_ext_irq_vector_second <= route.second;
    end
  end

  // clock configuration; reset values match the erased option byte
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_osc_source_select <= SRC_INTERNAL_RC;
      o_osc_range_select <= RANGE_VERY_LOW_POWER;
      o_doubler_enable <= 1'b0;
    end else begin
      o_osc_source_select <= next_source;
      o_osc_range_select <= next_range;
      o_doubler_enable <= sampled && next_doubler;
    end
  end

  // status; illegal settings are flagged only, the clock tree is not overridden
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_config_valid <= 1'b0;
      o_config_illegal <= 1'b0;
    end else begin
      o_config_valid <= sampled;
      o_config_illegal <= sampled && next_illegal;
    end
  end
endmodule // option_byte_config_decode

// file: tb/option_decode_asserts.sv
// checker for the option byte decoder, bound to its top ports
// assumes option bytes only change while reset is asserted
module option_decode_asserts
  import option_cfg_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic [7:0] i_option_byte0,
  input wire logic [7:0] i_option_byte1,
  input wire logic [7:0] i_porta_irq,
  input wire logic [7:0] i_portb_irq,
  input wire logic [5:0] i_portc_irq,
  input wire logic i_flash_write_req,
  input wire logic o_flash_write_lock,
  input wire logic o_flash_write_grant,
  input wire logic o_portc_irq_map_select,
  input wire logic o_ext_irq_vector_first,
  input wire logic o_ext_irq_vector_second,
  input wire osc_source_type o_osc_source_select,
  input wire osc_range_type o_osc_range_select,
  input wire logic o_doubler_enable,
  input wire logic o_config_valid,
  input wire logic o_config_illegal
);
  timeunit 1ns;
  timeprecision 1ns;
  // expected decode, worked out from the raw byte
  wire [7:0] b1 = i_option_byte1;
  wire [2:0] exp_rng = b1[3] ? 3'h0 : {1'b0, b1[2:1]} + 3'h1;
  wire exp_bad = (b1[5:4] == 2'h1) || (!b1[0] && (b1[5:4] == 2'h2 || b1[3:1] != 3'h1));
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  // outputs stay unloaded while the sync chain fills
  sequence s_settle; !o_config_valid [*2]; endsequence
  sequence s_loaded; ##[1:30] o_config_valid; endsequence
  a_valid_after: assert property ($rose(i_arst_n) |-> s_settle ##0 s_loaded)
    else $error("config never became valid");
  a_config_held: assert property (o_config_valid |=> o_config_valid &&
    $stable({o_flash_write_lock, o_portc_irq_map_select, o_osc_source_select,
    o_osc_range_select, o_doubler_enable}))
    else $error("config outputs moved");
  a_lock_decode: assert property (o_config_valid |->
    o_flash_write_lock == i_option_byte0[0])
    else $error("lock decode wrong");
  a_lock_refuses: assert property (o_flash_write_lock |-> !o_flash_write_grant)
    else $error("grant while locked");
  a_grant_follows: assert property ($past(o_config_valid) |->
    o_flash_write_grant == ($past(i_flash_write_req) && !o_flash_write_lock))
    else $error("grant wrong");
  a_first_route: assert property (o_config_valid && $past(o_config_valid, 2) |->
    o_ext_irq_vector_first == (|$past(i_porta_irq, 2) ||
    (!o_portc_irq_map_select && |$past(i_portc_irq, 2))))
    else $error("first vector wrong");
  a_second_route: assert property (o_config_valid && $past(o_config_valid, 2) |->
    o_ext_irq_vector_second == (|$past(i_portb_irq, 2) ||
    (o_portc_irq_map_select && |$past(i_portc_irq, 2))))
    else $error("second vector wrong");
  a_map_decode: assert property (o_config_valid |-> o_portc_irq_map_select == b1[7])
    else $error("map decode wrong");
  a_src_decode: assert property (o_config_valid |-> o_osc_source_select == b1[5:4])
    else $error("source decode wrong");
  a_range_decode: assert property (o_config_valid |-> o_osc_range_select == exp_rng)
    else $error("range decode wrong");
  a_doubler_decode: assert property (o_config_valid |-> o_doubler_enable == !b1[0])
    else $error("doubler decode wrong");
  a_illegal_flag: assert property (o_config_valid |-> o_config_illegal == exp_bad)
    else $error("illegal flag wrong");
endmodule // option_decode_asserts

bind option_byte_config_decode option_decode_asserts option_decode_asserts_inst (
  .i_clock, .i_arst_n, .i_option_byte0, .i_option_byte1, .i_porta_irq, .i_portb_irq,
  .i_portc_irq, .i_flash_write_req, .o_flash_write_lock, .o_flash_write_grant,
  .o_portc_irq_map_select, .o_ext_irq_vector_first, .o_ext_irq_vector_second,
  .o_osc_source_select, .o_osc_range_select, .o_doubler_enable, .o_config_valid,
  .o_config_illegal);

// file: tb/opt_prog_model.sv
// programming tool model holding both option bytes as static levels
// assumes writes arrive only while the device sits in programming mode
module opt_prog_model (
  input wire logic i_clock,
  input wire logic i_prog_mode,
  input wire logic [7:0] i_wr_byte0,
  input wire logic [7:0] i_wr_byte1,
  output logic [7:0] o_byte0,
  output logic [7:0] o_byte1
);
  timeunit 1ns;
  timeprecision 1ns;
  // nonvolatile store, erased at power up; no reset, it survives device resets
  logic [7:0] store0 = option_cfg_pkg::OPT0_RESET;
  logic [7:0] store1 = option_cfg_pkg::OPT1_RESET;

  assign o_byte0 = store0;
  assign o_byte1 = store1;

  // once locked the store refuses every rewrite
  always_ff @(posedge i_clock) begin
    if (i_prog_mode && !store0[0]) begin
      store0 <= i_wr_byte0;
      store1 <= {i_wr_byte1[7], 1'b1, i_wr_byte1[5:0]};
    end
  end
endmodule // opt_prog_model

// file: tb/tb_top.sv
// self-checking bench for the option byte decoder
// assumes the bound checker watches routing and grant timing
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import option_cfg_pkg::*;
  logic i_clock = 0, i_arst_n = 0, prog = 0, req = 0, was_valid = 0;
  logic [7:0] w0 = 0, w1 = 0, b0, b1, pa = 0, pb = 0, s0 = 8'hFC, s1;
  logic [5:0] pc = 0;
  logic lock, grant, map, v1, v2, dbl, valid, bad;
  osc_source_type src;
  osc_range_type rng;
  logic [8:0] expq[$];
  logic [31:0] seed = 32'hc326;
  int error_cnt = 0, check_count = 0;
  logic [7:0] cfg [6] = '{8'hC2, 8'h3F, 8'h61, 8'hE2, 8'h55, 8'h46};
  opt_prog_model opt_prog_model_inst (.i_clock, .i_prog_mode(prog), .i_wr_byte0(w0),
    .i_wr_byte1(w1), .o_byte0(b0), .o_byte1(b1));
  option_byte_config_decode option_byte_config_decode_inst (.i_clock, .i_arst_n,
    .i_option_byte0(b0), .i_option_byte1(b1), .i_porta_irq(pa), .i_portb_irq(pb),
    .i_portc_irq(pc), .i_flash_write_req(req), .o_flash_write_lock(lock),
    .o_flash_write_grant(grant), .o_portc_irq_map_select(map), .o_ext_irq_vector_first(v1),
    .o_ext_irq_vector_second(v2), .o_osc_source_select(src), .o_osc_range_select(rng),
    .o_doubler_enable(dbl), .o_config_valid(valid), .o_config_illegal(bad));
  initial begin
    forever #10 i_clock = ~i_clock;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t config got %h exp %h", $time, got, exp);
    end
  endtask
  // program in reset, note the decode, release, then toggle lines
  task automatic run_cfg(input logic [7:0] c0, input logic [7:0] c1);
    logic [2:0] r;
    i_arst_n <= 1'b0;
    prog <= 1'b1;
    w0 <= c0;
    w1 <= c1;
    if (!s0[0]) {s0, s1} = {c0, c1};
    r = s1[3] ? 3'h0 : {1'b0, s1[2:1]} + 3'h1;
    expq.push_back({s0[0], s1[7], s1[5:4], r, !s1[0], (s1[5:4] == 2'h1) ||
      (!s1[0] && (s1[5:4] == 2'h2 || s1[3:1] != 3'h1))});
    @(posedge i_clock);
    prog <= 1'b0;
    @(posedge i_clock);
    i_arst_n <= 1'b1;
    repeat (12) begin
      @(posedge i_clock);
      seed = xs(seed);
      {pa, pb, pc} <= (seed[4:0] < 5'h16) ? (22'h00_0001 << seed[4:0]) : 22'h00_0000;
      req <= seed[31];
    end
  endtask
  task automatic print_verdict();
    if (expq.size() != 0) error_cnt++;
    if (error_cnt == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // looked at mid-cycle, clear of the edge that launches the outputs
  always @(negedge i_clock) begin
    if (valid === 1'b1 && !was_valid && expq.size() > 0)
      chk({lock, map, src, rng, dbl, bad}, expq.pop_front());
    was_valid <= valid;
  end
  initial begin
    repeat (4) @(posedge i_clock);
    foreach (cfg[k]) run_cfg(8'hFC, cfg[k]);
    repeat (4) begin
      seed = xs(seed);
      run_cfg({seed[15:9], 1'b0}, seed[7:0]);
    end
    run_cfg(8'hFD, 8'hC2); // lock set, grants refused from here on
    run_cfg(8'hFC, 8'h3F); // rewrite attempt must not undo the lock
    print_verdict();
  end
  // whole run is a few microseconds
  initial begin
    #100000;
    error_cnt++;
    print_verdict();
  end
endmodule // tb_top
